// *** inc/lsfs_defs.svh ***
`ifndef LSFS_DEFS_SVH
`define LSFS_DEFS_SVH

// Timebase and interval figures
`define LSFS_CLK_HZ 40000000
`define LSFS_IDLE_US 4000
`define LSFS_FAULT_US 128000
`define LSFS_RAMP_US 200
`define LSFS_IDLE_CYC ((`LSFS_CLK_HZ / 1000000) * `LSFS_IDLE_US)
`define LSFS_FAULT_CYC ((`LSFS_CLK_HZ / 1000000) * `LSFS_FAULT_US)
`define LSFS_RAMP_CYC ((`LSFS_CLK_HZ / 1000000) * `LSFS_RAMP_US)
`define LSFS_RAMP_STEPS 16
`define LSFS_RAMP_FULL 4'hF
`define LSFS_RAMP_ZERO 4'h0

`endif

// *** inc/lsfs_pkg.sv ***
package lsfs_pkg;
    typedef enum logic [1:0] {
        lsfs_ch_run,
        lsfs_ch_hold,
        lsfs_ch_retest
    } lsfs_ch_state_t;
    typedef logic [3:0] lsfs_level_t;
endpackage

// *** design/lsfs_sync.sv ***
`timescale 1ns/1ps
module lsfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage is read by the second stage only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (clk_en) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // lsfs_sync

// *** design/lsfs_channel.sv ***
`timescale 1ns/1ps
`include "lsfs_defs.svh"
module lsfs_channel
    import lsfs_pkg::*;
#(
    parameter int FAULT_CYC = `LSFS_FAULT_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic allow,
    input wire logic dim,
    input wire logic open_short,
    output logic sink_on,
    output logic fault_active
);
    localparam int CW = $clog2(FAULT_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(FAULT_CYC - 1);

    lsfs_ch_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    wire cnt_done = (cnt_ff == LAST);
    wire detect = allow && dim && open_short;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = '0;
        case (state_ff)
            lsfs_ch_run: begin
                if (detect) nxt_state = lsfs_ch_hold;
            end
            lsfs_ch_hold: begin
                // Fault window timed on the internal timebase
                nxt_cnt = cnt_ff + CW'(1);
                if (cnt_done) begin
                    nxt_cnt = '0;
                    nxt_state = lsfs_ch_retest;
                end
            end
            lsfs_ch_retest: begin
                // One-cycle probe: sink on so the condition can be seen
                if (open_short) nxt_state = lsfs_ch_hold;
                else nxt_state = lsfs_ch_run;
            end
            default: nxt_state = lsfs_ch_run;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= lsfs_ch_run;
            cnt_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Channel follows its own dim input while allow is high, unless it is faulted
    assign sink_on = allow && (state_ff == lsfs_ch_run ? dim :
                     state_ff == lsfs_ch_retest);
    assign fault_active = (state_ff == lsfs_ch_hold);
endmodule // lsfs_channel

// *** design/lsfs_top.sv ***
`timescale 1ns/1ps
`include "lsfs_defs.svh"
// Behaviour
// - Headroom-good withheld if any enabled channel is at dropout.
// - Channels with dim input low are ignored for headroom.
// - Headroom-good driven when all evaluated channels have headroom.
// - Channels off while supply lockout comparator is active.
// - Fault line held low throughout supply lockout.
// - Open or short: fault low 128ms, then retest the channel.
// - Retest clear re-enables channel, else repeat fault and retest.
// - Unaffected channels keep following their own dim input.
// - Over-temperature turns off all current sinks.
// - Leave shutdown only when cool, then soft-start ramp.
// - Fault line held low throughout thermal shutdown.
// - Fault line is open-drain, only pulls low.
// - All dim inputs low for 4ms enters low-power mode.
// - Enable with valid supply ramps current over about 200us.
// - Any dim activity leaves low-power mode at once.
// - Sink on while dim input high, off while low.
module lsfs_top
    import lsfs_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int IDLE_CYC = `LSFS_IDLE_CYC,
    parameter int FAULT_CYC = `LSFS_FAULT_CYC,
    parameter int RAMP_CYC = `LSFS_RAMP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [NUM_CH-1:0] channel_dim_in,
    input wire logic [NUM_CH-1:0] sink_dropout_in,
    input wire logic [NUM_CH-1:0] open_short_in,
    input wire logic supply_lockout_in,
    input wire logic thermal_hot_in,
    input wire logic thermal_cool_in,
    output logic [NUM_CH-1:0] channel_sink_out,
    output lsfs_level_t sink_level_out,
    output logic headroom_good_out,
    output logic shared_fault_n_o,
    output logic shared_fault_n_oe,
    output logic low_power_out
);
    localparam int SYNC_W = 3 * NUM_CH + 3;
    localparam int IW = $clog2(IDLE_CYC + 1);
    localparam int STEP_CYC = (RAMP_CYC + `LSFS_RAMP_STEPS - 1) /
                              `LSFS_RAMP_STEPS;
    localparam int RW = $clog2(STEP_CYC + 1);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYC - 1);
    localparam logic [RW-1:0] STEP_LAST = RW'(STEP_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Synchronise pins and analog comparator results
    logic [SYNC_W-1:0] sync_bus;
    logic [NUM_CH-1:0] dim_s;
    logic [NUM_CH-1:0] dropout_s;
    logic [NUM_CH-1:0] open_short_s;
    logic lockout_s;
    logic hot_s;
    logic cool_s;

    lsfs_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({channel_dim_in, sink_dropout_in, open_short_in,
                   supply_lockout_in, thermal_hot_in, thermal_cool_in}),
        .sync_out(sync_bus)
    );

    assign {dim_s, dropout_s, open_short_s, lockout_s, hot_s, cool_s} =
        sync_bus;

    ////////////////////////////////////////////////////////////////////////
    // Thermal shutdown with hysteresis between the two comparators
    logic shutdown_ff;
    logic nxt_shutdown;

    assign nxt_shutdown = hot_s ? 1'b1 :
                          (cool_s ? 1'b0 : shutdown_ff);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shutdown_ff <= 1'b0;
        end else if (clk_en) begin
            shutdown_ff <= nxt_shutdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle detection and low-power mode
    logic [IW-1:0] idle_cnt_ff;
    logic [IW-1:0] nxt_idle_cnt;
    logic low_power_ff;
    logic nxt_low_power;
    wire any_dim = |dim_s;
    wire idle_done = (idle_cnt_ff == IDLE_LAST);

    assign nxt_idle_cnt = (any_dim || idle_done) ? '0 :
                          idle_cnt_ff + IW'(1);
    assign nxt_low_power = any_dim ? 1'b0 :
                           (idle_done ? 1'b1 : low_power_ff);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_cnt_ff <= '0;
            low_power_ff <= 1'b1;
        end else if (clk_en) begin
            idle_cnt_ff <= low_power_ff ? '0 : nxt_idle_cnt;
            low_power_ff <= nxt_low_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft-start ramp, restarted by lockout, shutdown or low power
    wire allow = !lockout_s && !shutdown_ff;
    wire ramp_hold = !allow || low_power_ff;
    lsfs_level_t level_ff;
    lsfs_level_t nxt_level;
    logic [RW-1:0] step_cnt_ff;
    logic [RW-1:0] nxt_step_cnt;
    wire step_done = (step_cnt_ff == STEP_LAST);
    wire at_full = (level_ff == `LSFS_RAMP_FULL);

    // Ramp only advances while some channel is asked to conduct
    assign nxt_step_cnt = (ramp_hold || at_full || step_done || !any_dim) ?
                          '0 : step_cnt_ff + RW'(1);
    assign nxt_level = ramp_hold ? `LSFS_RAMP_ZERO :
                       ((step_done && !at_full) ? level_ff + 4'h1 :
                        level_ff);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step_cnt_ff <= '0;
            level_ff <= `LSFS_RAMP_ZERO;
        end else if (clk_en) begin
            step_cnt_ff <= nxt_step_cnt;
            level_ff <= nxt_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel enable and open/short supervision
    logic [NUM_CH-1:0] ch_sink;
    logic [NUM_CH-1:0] ch_fault;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            lsfs_channel #(
                .FAULT_CYC(FAULT_CYC)
            ) u_ch (
                .core_clk(core_clk),
                .rst(rst),
                .clk_en(clk_en),
                .allow(allow),
                .dim(dim_s[gi]),
                .open_short(open_short_s[gi]),
                .sink_on(ch_sink[gi]),
                .fault_active(ch_fault[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    wire starved = |(dim_s & ch_sink & dropout_s);
    wire fault_any = lockout_s || shutdown_ff || (|ch_fault);
    logic [NUM_CH-1:0] sink_ff;
    logic headroom_ff;
    logic fault_ff;
    lsfs_level_t out_level_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sink_ff <= '0;
            headroom_ff <= 1'b0;
            fault_ff <= 1'b0;
            out_level_ff <= `LSFS_RAMP_ZERO;
        end else if (clk_en) begin
            sink_ff <= ch_sink;
            headroom_ff <= allow && !starved;
            fault_ff <= fault_any;
            out_level_ff <= nxt_level;
        end
    end

    assign channel_sink_out = sink_ff;
    assign sink_level_out = out_level_ff;
    assign headroom_good_out = headroom_ff;
    assign low_power_out = low_power_ff;
    // Open drain: never drive high, so wired devices cannot fight
    assign shared_fault_n_o = 1'b0;
    assign shared_fault_n_oe = fault_ff;
endmodule // lsfs_top

// *** sim/lsfs_mcu_model.sv ***
`timescale 1ns/1ps
module lsfs_mcu_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] dim_cmd,
    input wire logic gang,
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    output logic [1:0] channel_dim_in,
    output logic fault_line,
    output logic irq_ff
);
    // Pull-up holds the shared line high unless a device sinks it
    assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
    // Paralleled strings must see one waveform, or current splits unevenly
    assign channel_dim_in = gang ? {2{dim_cmd[0]}} : dim_cmd;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) irq_ff <= 1'b0;
        else irq_ff <= !fault_line;
    end
endmodule // lsfs_mcu_model

// *** sim/lsfs_top_props.sv ***
`timescale 1ns/1ps
module lsfs_chk
    import lsfs_pkg::*;
#(
    parameter int IDLE_CYC = 40,
    parameter int FAULT_CYC = 50
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] channel_dim_in,
    input wire logic [1:0] sink_dropout_in,
    input wire logic [1:0] open_short_in,
    input wire logic supply_lockout_in,
    input wire logic thermal_hot_in,
    input wire logic thermal_cool_in,
    input wire logic [1:0] channel_sink_out,
    input wire lsfs_level_t sink_level_out,
    input wire logic headroom_good_out,
    input wire logic shared_fault_n_o,
    input wire logic shared_fault_n_oe,
    input wire logic low_power_out
);
    logic calm;
    int idle_ff;
    int oe_ff;
    assign calm = !supply_lockout_in && !thermal_hot_in && thermal_cool_in;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_ff <= 0;
            oe_ff <= 0;
        end else begin
            idle_ff <= (channel_dim_in == 2'h0) ? idle_ff + 1 : 0;
            oe_ff <= shared_fault_n_oe ? oe_ff + 1 : 0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_probe;
        $fell(shared_fault_n_oe) && open_short_in[0] && channel_dim_in[0];
    endsequence
    property p_lock;
        supply_lockout_in[*6] |-> channel_sink_out == 2'h0 && shared_fault_n_oe;
    endproperty
    property p_hot;
        thermal_hot_in[*6] |-> channel_sink_out == 2'h0 && shared_fault_n_oe
            && sink_level_out == 4'h0;
    endproperty
    property p_od;
        shared_fault_n_oe |-> !shared_fault_n_o;
    endproperty
    property p_hr_low;
        (|(channel_dim_in & sink_dropout_in & channel_sink_out))[*5]
            |-> !headroom_good_out;
    endproperty
    property p_hr_ok;
        (calm && channel_dim_in != 2'h0 && open_short_in == 2'h0
            && (channel_dim_in & sink_dropout_in) == 2'h0)[*8]
            |-> headroom_good_out;
    endproperty
    property p_idle;
        idle_ff == IDLE_CYC + 6 |-> low_power_out;
    endproperty
    property p_early;
        $rose(low_power_out) |-> idle_ff >= IDLE_CYC;
    endproperty
    property p_wake;
        (channel_dim_in != 2'h0)[*4] |-> !low_power_out;
    endproperty
    property p_hold;
        $fell(shared_fault_n_oe) && calm |-> oe_ff >= FAULT_CYC;
    endproperty
    property p_again;
        s_probe ##0 calm |-> ##[1:4] shared_fault_n_oe;
    endproperty
    property p_ramp;
        $changed(sink_level_out) && sink_level_out != 4'h0
            |-> sink_level_out == $past(sink_level_out) + 4'h1;
    endproperty
    property p_off;
        (!channel_dim_in[1])[*4] |-> !channel_sink_out[1];
    endproperty
    a_lock: assert property (p_lock) else $error("sink on in lockout");
    a_hot: assert property (p_hot) else $error("sink on when hot");
    a_od: assert property (p_od) else $error("fault drives high");
    a_hr_low: assert property (p_hr_low) else $error("headroom high");
    a_hr_ok: assert property (p_hr_ok) else $error("headroom low");
    a_idle: assert property (p_idle) else $error("no low power");
    a_early: assert property (p_early) else $error("low power early");
    a_wake: assert property (p_wake) else $error("stuck low power");
    a_hold: assert property (p_hold) else $error("fault too short");
    a_again: assert property (p_again) else $error("no refault");
    a_ramp: assert property (p_ramp) else $error("ramp jumped");
    a_off: assert property (p_off) else $error("sink on, dim low");
endmodule // lsfs_chk
bind lsfs_top lsfs_chk #(.IDLE_CYC(IDLE_CYC), .FAULT_CYC(FAULT_CYC))
    lsfs_chk_inst (.core_clk(core_clk), .rst(rst),
    .channel_dim_in(channel_dim_in), .sink_dropout_in(sink_dropout_in),
    .open_short_in(open_short_in), .supply_lockout_in(supply_lockout_in),
    .thermal_hot_in(thermal_hot_in), .thermal_cool_in(thermal_cool_in),
    .channel_sink_out(channel_sink_out), .sink_level_out(sink_level_out),
    .headroom_good_out(headroom_good_out), .low_power_out(low_power_out),
    .shared_fault_n_o(shared_fault_n_o), .shared_fault_n_oe(shared_fault_n_oe));

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
    import lsfs_pkg::*;
    localparam int IC = 40;
    localparam int FC = 50;
    logic core_clk = 0, rst = 1, gang = 0, lock = 0, hot = 0, cool = 1;
    logic [1:0] dim_cmd = 0, drop = 0, os = 0, dim, sink;
    logic hr, fo, foe, lp, fl, irq;
    lsfs_level_t lvl;
    int n_fail = 0, cmp_count = 0, n;
    always #12.5 core_clk = ~core_clk;
    lsfs_top #(.IDLE_CYC(IC), .FAULT_CYC(FC), .RAMP_CYC(32)) lsfs_top_inst (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .channel_dim_in(dim),
        .sink_dropout_in(drop), .open_short_in(os), .supply_lockout_in(lock),
        .thermal_hot_in(hot), .thermal_cool_in(cool), .channel_sink_out(sink),
        .sink_level_out(lvl), .headroom_good_out(hr), .shared_fault_n_o(fo),
        .shared_fault_n_oe(foe), .low_power_out(lp));
    lsfs_mcu_model lsfs_mcu_model_inst (.core_clk(core_clk), .rst(rst),
        .dim_cmd(dim_cmd), .gang(gang), .fault_n_o(fo), .fault_n_oe(foe),
        .channel_dim_in(dim), .fault_line(fl), .irq_ff(irq));
    ////////////////////////////////////////////////////////////////////////
    task step(input int k); repeat (k) @(posedge core_clk); #1; endtask
    task results;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Retest probe is a single cycle, so poll every cycle
    task wait_s0;
        n = 0;
        while (sink[0] !== 1'b1) begin
            step(1);
            n++;
            if (n > 300) begin n_fail++; results(); end
        end
    endtask
    task t_idle;
        dim_cmd = 2'h1; step(4);
        `CHK(lp, 1'b0)
        `CHK(sink, 2'h1)
        step(40);
        `CHK(lvl, 4'hF)
        dim_cmd = 2'h0; step(IC - 4);
        `CHK(lp, 1'b0)
        step(10);
        `CHK(lp, 1'b1)
    endtask
    task t_head;
        dim_cmd = 2'h3; drop = 2'h2; step(8);
        `CHK(hr, 1'b0)
        dim_cmd = 2'h1; step(8);
        `CHK(hr, 1'b1)
        dim_cmd = 2'h3; drop = 2'h0; step(8);
        `CHK(hr, 1'b1)
    endtask
    task t_lock;
        lock = 1; step(6);
        `CHK(sink, 2'h0)
        `CHK(fl, 1'b0)
        `CHK(irq, 1'b1)
        step(60); lock = 0; step(8);
        `CHK(sink, 2'h3)
        `CHK(fl, 1'b1)
    endtask
    task t_hot;
        gang = 1; dim_cmd = 2'h1; hot = 1; cool = 0; step(30);
        `CHK(sink, 2'h0)
        `CHK(fl, 1'b0)
        hot = 0; step(30);
        `CHK(sink, 2'h0)
        cool = 1; step(6);
        `CHK(sink, 2'h3)
        `CHK(lvl < 4'hF, 1'b1)
        step(40);
        `CHK(lvl, 4'hF)
        gang = 0;
    endtask
    task t_fault;
        dim_cmd = 2'h3; os = 2'h1; step(6);
        `CHK(sink, 2'h2)
        `CHK(fl, 1'b0)
        dim_cmd = 2'h1; step(4);
        `CHK(sink, 2'h0)
        dim_cmd = 2'h3; wait_s0();
        `CHK(n >= FC - 10 && n <= FC - 2, 1'b1)
        step(6);
        `CHK(sink[0], 1'b0)
        `CHK(fl, 1'b0)
        os = 2'h0; wait_s0(); step(6);
        `CHK(sink, 2'h3)
        `CHK(fl, 1'b1)
    endtask
    initial begin
        step(2); rst = 0; step(2);
        t_idle(); t_head(); t_lock(); t_hot(); t_fault();
        results();
    end
endmodule // tb_top
